// ===== shared/pfc_pkg.sv
// Constants, register map and carrier types of the pause flow-control engine
package pfc_pkg;

	// Register byte offsets
	localparam logic [7:0]  PFC_OFS_CTRL      = 8'h00;
	localparam logic [7:0]  PFC_OFS_PTIME     = 8'h04;
	localparam logic [7:0]  PFC_OFS_REFRESH   = 8'h08;
	localparam logic [7:0]  PFC_OFS_THRESH    = 8'h0C;
	localparam logic [7:0]  PFC_OFS_STA_LO    = 8'h10;
	localparam logic [7:0]  PFC_OFS_STA_HI    = 8'h14;
	localparam logic [7:0]  PFC_OFS_STATUS    = 8'h18;

	// Control and threshold register field positions
	localparam int          PFC_CTRL_RXFC     = 0;
	localparam int          PFC_CTRL_TXFC     = 1;
	localparam int          PFC_CTRL_SMB      = 2;
	localparam int          PFC_THR_LO_POS    = 16;

	// Reset values
	localparam logic [2:0]  PFC_CTRL_RST      = 3'h0;
	localparam logic [15:0] PFC_PTIME_RST     = 16'h0200;
	localparam logic [15:0] PFC_REFRESH_RST   = 16'h0100;
	localparam logic [15:0] PFC_THR_HI_RST    = 16'h0800;
	localparam logic [15:0] PFC_THR_LO_RST    = 16'h0400;
	localparam logic [47:0] PFC_STA_RST       = 48'h0;

	// Frame checks
	localparam logic [47:0] PFC_MC_ADDR       = 48'h0180C2000001;
	localparam logic [15:0] PFC_CTRL_TYPE     = 16'h8808;
	localparam logic [15:0] PFC_PAUSE_OPCODE  = 16'h0001;

	// Byte positions and byte counts inside a received frame
	localparam logic [4:0]  PFC_IDX_DA_END    = 5'h05;
	localparam logic [4:0]  PFC_IDX_TYPE      = 5'h0C;
	localparam logic [4:0]  PFC_IDX_OPCODE    = 5'h0E;
	localparam logic [4:0]  PFC_IDX_TIMER     = 5'h10;
	localparam logic [4:0]  PFC_MIN_BYTES     = 5'h12;
	localparam logic [4:0]  PFC_CNT_MAX       = 5'h1F;

	// One slot time in byte times
	localparam int          PFC_SLOT_BYTES    = 64;

	// One received byte with its frame markers
	typedef struct packed {
		logic       sof;
		logic       eof;
		logic [7:0] data;
	} pfc_beat_t;

	// PAUSE frame to be transmitted
	typedef struct packed {
		logic        xon;
		logic [15:0] timer;
	} pfc_pause_req_t;

endpackage

// ===== rtl/pfc_pause_timer.sv
// Pause timer counting in slot times of byte ticks
`timescale 1ns/1ps
module pfc_pause_timer #(
	parameter int W    = 16,
	parameter int SLOT = pfc_pkg::PFC_SLOT_BYTES
) (
	// Clock and reset
	input  wire logic         clk_sys_in,
	input  wire logic         srst_in,
	input  wire logic         clk_en_in,
	// Control
	input  wire logic         byte_tick_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] load_val_in,
	input  wire logic         clear_in,
	// State
	output logic [W-1:0]      count_out,
	output logic              expire_out,
	output logic              slot_tick_out
);
	import pfc_pkg::*;

	localparam int PW = $clog2(SLOT);
	localparam logic [PW-1:0] PRE_LAST = PW'(SLOT - 1);

	logic [PW-1:0] pre_q, pre_d;
	logic [W-1:0]  cnt_q, cnt_d;
	logic          tick_q, tick_d;
	logic          exp_q, exp_d;

	always_comb begin
		pre_d  = pre_q;
		tick_d = 1'b0;
		if (byte_tick_in) begin
			tick_d = (pre_q == PRE_LAST);
			pre_d  = (pre_q == PRE_LAST) ? '0 : pre_q + 1'b1;
		end
		cnt_d = cnt_q;
		exp_d = 1'b0;
		if (load_in) begin
			cnt_d = load_val_in;
		end else if (clear_in) begin
			cnt_d = '0;
		end else if (tick_q && cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
			exp_d = (cnt_q == W'(1));
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			pre_q  <= '0;
			cnt_q  <= '0;
			tick_q <= 1'b0;
			exp_q  <= 1'b0;
		end else if (clk_en_in) begin
			pre_q  <= pre_d;
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
			exp_q  <= exp_d;
		end
	end

	assign count_out     = cnt_q;
	assign expire_out    = exp_q;
	assign slot_tick_out = tick_q;

	default clocking cb @(posedge clk_sys_in iff clk_en_in); endclocking
	default disable iff (srst_in);

	chk_slot_spacing: assert property (
		tick_q |-> pre_q == '0
	) else $error("slot tick off the 64 byte boundary");

	chk_timer_decrement: assert property (
		tick_q && cnt_q != '0 && !load_in && !clear_in
		|=> cnt_q == $past(cnt_q) - 1'b1
	) else $error("pause timer did not step down on slot tick");

endmodule // pfc_pause_timer

// ===== rtl/pfc_flow_ctrl.sv
// Pause flow-control engine: receive checks, halt, status and PAUSE requests
// What this block does
// - Candidate only if destination is control multicast or station address.
// - Length/type field must equal 0x8808.
// - Control opcode must equal 0x0001 for a valid PAUSE.
// - Non-zero timer means XOFF; zero means XON, cancelling pause.
// - Timer counts slot times of 64 byte times each.
// - Received pause frames act only while receive flow control enabled.
// - XOFF loads the pause timer from the frame's timer field.
// - XOFF halts transmit now, or after the packet in flight.
// - XOFF sends an in-band status with transmit-halted set.
// - Validated XOFF and XON frames are forwarded to the controller.
// - Transmit resumes on timer expiry or XON, whichever first.
// - XON re-enables transmit and sends status with halted cleared.
// - Outside SMBus mode, controller send-pause command transmits PAUSE with configured pause time.
// - SMBus mode: fill above high threshold transmits XOFF.
// - SMBus mode: fill below low threshold transmits XON.
// - SMBus mode: still above low after refresh interval resends XOFF.
// - Pause time value is a 16-bit configurable register.
// - Pause refresh interval is a 16-bit configurable register.
// - Status messages go out only in a receive inter-packet gap.
`timescale 1ns/1ps
module pfc_flow_ctrl #(
	parameter int FILL_W = 16
) (
	// Clock, reset, enable
	input  wire logic                  clk_sys_in,
	input  wire logic                  srst_in,
	input  wire logic                  clk_en_in,
	// Register port
	input  wire logic [7:0]            reg_addr_in,
	input  wire logic [31:0]           reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic [31:0]                reg_rdata_out,
	// Receive stream
	input  wire logic                  rx_valid_in,
	input  wire pfc_pkg::pfc_beat_t    rx_beat_in,
	// Forwarded stream to controller
	output logic                       fwd_valid_out,
	output pfc_pkg::pfc_beat_t         fwd_beat_out,
	output logic                       fwd_pause_out,
	// Transmit path
	input  wire logic                  byte_tick_in,
	input  wire logic                  tx_busy_in,
	output logic                       tx_halt_out,
	// In-band messages
	input  wire logic                  ib_cmd_valid_in,
	input  wire logic                  ib_cmd_xon_in,
	output logic                       ib_stat_valid_out,
	output logic                       ib_stat_txoff_out,
	// PAUSE transmit request
	output logic                       pause_req_valid_out,
	output pfc_pkg::pfc_pause_req_t    pause_req_out,
	input  wire logic                  pause_req_ack_in,
	// FIFO fill levels
	input  wire logic [FILL_W-1:0]     rx_fill_in,
	input  wire logic [FILL_W-1:0]     tx_fill_in
);
	import pfc_pkg::*;

	// Configuration registers
	logic [2:0]  ctrl_q, ctrl_d;
	logic [15:0] ptime_q, ptime_d, refresh_q, refresh_d;
	logic [15:0] thr_hi_q, thr_hi_d, thr_lo_q, thr_lo_d;
	logic [47:0] sta_q, sta_d;
	logic [31:0] rdata_q, rdata_d;

	// Receive parser
	logic [4:0]  bcnt_q, bcnt_d;
	logic        in_pkt_q, in_pkt_d, fend_q, fend_d;
	logic [47:0] da_q, da_d;
	logic [15:0] type_q, type_d, op_q, op_d, tmr_q, tmr_d;
	logic        fwd_v_q;
	pfc_beat_t   fwd_b_q;
	logic        fwd_p_q, fwd_p_d;

	// Transmit halt and status
	logic        halt_q, halt_d;
	logic        pend_q, pend_d, poff_q, poff_d;
	logic        sv_q, sv_d, soff_q, soff_d;

	// PAUSE requests
	logic           req_v_q, req_v_d;
	pfc_pause_req_t req_q, req_d;
	logic           xsent_q, xsent_d;
	logic [15:0]    rcnt_q, rcnt_d;

	// Timer wiring
	logic [15:0] tcnt;
	logic        texp, slot_tick;
	logic        addr_ok, type_ok, op_ok, pause_ok, xoff_w, xon_w;
	logic        gap_w, cmd_ok, resume_w;
	logic [FILL_W:0] fill_sum;

	function automatic logic [15:0] be16(input logic [15:0] v,
	                                     input logic [7:0] b);
		be16 = {v[7:0], b};
	endfunction

	always_comb begin
		addr_ok  = (da_q == PFC_MC_ADDR) || (da_q == sta_q);
		type_ok  = (type_q == PFC_CTRL_TYPE);
		op_ok    = (op_q == PFC_PAUSE_OPCODE);
		pause_ok = fend_q && ctrl_q[PFC_CTRL_RXFC] && addr_ok && type_ok
		           && op_ok && (bcnt_q >= PFC_MIN_BYTES);
		xoff_w   = pause_ok && (tmr_q != '0);
		xon_w    = pause_ok && (tmr_q == '0);
		gap_w    = !in_pkt_q && !rx_valid_in;
		cmd_ok   = ib_cmd_valid_in && gap_w
		           && !ctrl_q[PFC_CTRL_SMB];
		resume_w = xon_w || (texp && !xoff_w);
		fill_sum = {1'b0, rx_fill_in} + {1'b0, tx_fill_in};
	end

	pfc_pause_timer #(
		.W    (16),
		.SLOT (PFC_SLOT_BYTES)
	) u_timer (
		.clk_sys_in    (clk_sys_in),
		.srst_in       (srst_in),
		.clk_en_in     (clk_en_in),
		.byte_tick_in  (byte_tick_in),
		.load_in       (xoff_w),
		.load_val_in   (tmr_q),
		.clear_in      (xon_w),
		.count_out     (tcnt),
		.expire_out    (texp),
		.slot_tick_out (slot_tick)
	);

	// Register port
	always_comb begin
		ctrl_d    = ctrl_q;
		ptime_d   = ptime_q;
		refresh_d = refresh_q;
		thr_hi_d  = thr_hi_q;
		thr_lo_d  = thr_lo_q;
		sta_d     = sta_q;
		rdata_d   = '0;
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				PFC_OFS_CTRL:    ctrl_d    = reg_wdata_in[2:0];
				PFC_OFS_PTIME:   ptime_d   = reg_wdata_in[15:0];
				PFC_OFS_REFRESH: refresh_d = reg_wdata_in[15:0];
				PFC_OFS_THRESH: begin
					thr_hi_d = reg_wdata_in[15:0];
					thr_lo_d = reg_wdata_in[PFC_THR_LO_POS +: 16];
				end
				PFC_OFS_STA_LO:  sta_d[31:0]  = reg_wdata_in;
				PFC_OFS_STA_HI:  sta_d[47:32] = reg_wdata_in[15:0];
				default: ;
			endcase
		end
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				PFC_OFS_CTRL:    rdata_d = {29'h0, ctrl_q};
				PFC_OFS_PTIME:   rdata_d = {16'h0, ptime_q};
				PFC_OFS_REFRESH: rdata_d = {16'h0, refresh_q};
				PFC_OFS_THRESH:  rdata_d = {thr_lo_q, thr_hi_q};
				PFC_OFS_STA_LO:  rdata_d = sta_q[31:0];
				PFC_OFS_STA_HI:  rdata_d = {16'h0, sta_q[47:32]};
				PFC_OFS_STATUS:  rdata_d = {12'h0, xsent_q, req_v_q, pend_q,
				                            halt_q, tcnt};
				default:         rdata_d = '0;
			endcase
		end
	end

	// Receive parser; a frame is judged one cycle after its last byte
	always_comb begin
		logic [4:0] idx;
		idx      = rx_beat_in.sof ? 5'h00 : bcnt_q;
		bcnt_d   = bcnt_q;
		in_pkt_d = in_pkt_q;
		da_d     = da_q;
		type_d   = type_q;
		op_d     = op_q;
		tmr_d    = tmr_q;
		fend_d   = 1'b0;
		fwd_p_d  = pause_ok;
		if (rx_valid_in) begin
			if (idx <= PFC_IDX_DA_END)
				da_d = {(rx_beat_in.sof ? 40'h0 : da_q[39:0]),
				        rx_beat_in.data};
			if (idx[4:1] == PFC_IDX_TYPE[4:1])
				type_d = be16(type_q, rx_beat_in.data);
			if (idx[4:1] == PFC_IDX_OPCODE[4:1])
				op_d = be16(op_q, rx_beat_in.data);
			if (idx[4:1] == PFC_IDX_TIMER[4:1])
				tmr_d = be16(tmr_q, rx_beat_in.data);
			bcnt_d   = (idx == PFC_CNT_MAX) ? idx : idx + 5'h01;
			in_pkt_d = !rx_beat_in.eof;
			fend_d   = rx_beat_in.eof;
		end
	end

	// Halt, resume and status messages
	always_comb begin
		// A packet in flight finishes before the halt takes hold
		if (tcnt != '0 && !resume_w)
			halt_d = halt_q || !tx_busy_in;
		else
			halt_d = 1'b0;
		pend_d = pend_q;
		poff_d = poff_q;
		sv_d   = 1'b0;
		soff_d = soff_q;
		if (pend_q && gap_w) begin
			sv_d   = 1'b1;
			soff_d = poff_q;
			pend_d = 1'b0;
		end
		// A new event stays pending while an older one is sent in the same cycle
		if (xoff_w) begin
			pend_d = 1'b1;
			poff_d = 1'b1;
		end else if (resume_w) begin
			pend_d = 1'b1;
			poff_d = 1'b0;
		end
	end

	// PAUSE requests from in-band commands or FIFO fill
	always_comb begin
		req_v_d = req_v_q && !pause_req_ack_in;
		req_d   = req_q;
		xsent_d = xsent_q;
		rcnt_d  = rcnt_q;
		if (xsent_q && slot_tick && rcnt_q != '1)
			rcnt_d = rcnt_q + 16'h0001;
		if (cmd_ok) begin
			req_v_d = 1'b1;
			req_d   = '{xon: ib_cmd_xon_in,
			            timer: ib_cmd_xon_in ? 16'h0000 : ptime_q};
		end else if (ctrl_q[PFC_CTRL_SMB] && !req_v_d) begin
			// Only one request is held; the FIFO check retries next cycle
			if (!xsent_q && fill_sum > {1'b0, thr_hi_q}) begin
				req_v_d = 1'b1;
				req_d   = '{xon: 1'b0, timer: ptime_q};
				xsent_d = 1'b1;
				rcnt_d  = '0;
			end else if (xsent_q && fill_sum < {1'b0, thr_lo_q}) begin
				req_v_d = 1'b1;
				req_d   = '{xon: 1'b1, timer: 16'h0000};
				xsent_d = 1'b0;
			end else if (xsent_q && rcnt_q >= refresh_q
			             && fill_sum > {1'b0, thr_lo_q}) begin
				req_v_d = 1'b1;
				req_d   = '{xon: 1'b0, timer: ptime_q};
				rcnt_d  = '0;
			end
		end else if (!ctrl_q[PFC_CTRL_SMB]) begin
			xsent_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			ctrl_q    <= PFC_CTRL_RST;
			ptime_q   <= PFC_PTIME_RST;
			refresh_q <= PFC_REFRESH_RST;
			thr_hi_q  <= PFC_THR_HI_RST;
			thr_lo_q  <= PFC_THR_LO_RST;
			sta_q     <= PFC_STA_RST;
			rdata_q   <= '0;
			bcnt_q    <= '0;
			in_pkt_q  <= 1'b0;
			fend_q    <= 1'b0;
			da_q      <= '0;
			type_q    <= '0;
			op_q      <= '0;
			tmr_q     <= '0;
			fwd_v_q   <= 1'b0;
			fwd_b_q   <= '0;
			fwd_p_q   <= 1'b0;
			halt_q    <= 1'b0;
			pend_q    <= 1'b0;
			poff_q    <= 1'b0;
			sv_q      <= 1'b0;
			soff_q    <= 1'b0;
			req_v_q   <= 1'b0;
			req_q     <= '0;
			xsent_q   <= 1'b0;
			rcnt_q    <= '0;
		end else if (clk_en_in) begin
			ctrl_q    <= ctrl_d;
			ptime_q   <= ptime_d;
			refresh_q <= refresh_d;
			thr_hi_q  <= thr_hi_d;
			thr_lo_q  <= thr_lo_d;
			sta_q     <= sta_d;
			rdata_q   <= rdata_d;
			bcnt_q    <= bcnt_d;
			in_pkt_q  <= in_pkt_d;
			fend_q    <= fend_d;
			da_q      <= da_d;
			type_q    <= type_d;
			op_q      <= op_d;
			tmr_q     <= tmr_d;
			fwd_v_q   <= rx_valid_in;
			fwd_b_q   <= rx_beat_in;
			fwd_p_q   <= fwd_p_d;
			halt_q    <= halt_d;
			pend_q    <= pend_d;
			poff_q    <= poff_d;
			sv_q      <= sv_d;
			soff_q    <= soff_d;
			req_v_q   <= req_v_d;
			req_q     <= req_d;
			xsent_q   <= xsent_d;
			rcnt_q    <= rcnt_d;
		end
	end

	assign reg_rdata_out       = rdata_q;
	assign fwd_valid_out       = fwd_v_q;
	assign fwd_beat_out        = fwd_b_q;
	assign fwd_pause_out       = fwd_p_q;
	assign tx_halt_out         = halt_q;
	assign ib_stat_valid_out   = sv_q;
	assign ib_stat_txoff_out   = soff_q;
	assign pause_req_valid_out = req_v_q;
	assign pause_req_out       = req_q;

	default clocking cb @(posedge clk_sys_in iff clk_en_in); endclocking
	default disable iff (srst_in);

	sequence s_gap_send;
		pend_q && gap_w;
	endsequence

	sequence s_xoff_seen;
		xoff_w ##1 (tcnt != '0);
	endsequence

	chk_frame_checks: assert property (
		(xoff_w || xon_w) |-> addr_ok && type_ok && op_ok
	) else $error("pause acted on without all frame checks");

	chk_rxfc_gate: assert property (
		!ctrl_q[PFC_CTRL_RXFC] |-> !xoff_w && !xon_w
	) else $error("pause acted on with receive flow control off");

	chk_xoff_load: assert property (
		xoff_w |=> tcnt == $past(tmr_q)
	) else $error("pause timer not loaded from frame");

	chk_halt_idle: assert property (
		s_xoff_seen ##0 (!tx_busy_in && !resume_w) |=> halt_q
	) else $error("transmit not halted while idle under pause");

	chk_xoff_status: assert property (
		xoff_w |=> pend_q && poff_q ##[0:300] sv_q && soff_q
	) else $error("no halted status after XOFF");

	chk_fwd_pause: assert property (
		pause_ok |=> fwd_pause_out
	) else $error("validated pause frame not flagged to controller");

	chk_xon_resume: assert property (
		xon_w |=> !halt_q && tcnt == '0 && pend_q && !poff_q
	) else $error("XON did not resume transmit");

	chk_stat_gap: assert property (
		s_gap_send |=> sv_q
	) else $error("status not sent in receive gap");

	chk_cmd_req: assert property (
		cmd_ok && !ib_cmd_xon_in |=> req_v_q && req_q.timer == $past(ptime_q)
	) else $error("send-pause command lost or wrong timer");

	chk_smb_xon: assert property (
		ctrl_q[PFC_CTRL_SMB] && !cmd_ok && xsent_q
		&& !(req_v_q && !pause_req_ack_in)
		&& fill_sum < {1'b0, thr_lo_q} |=> req_v_q && req_q.xon && !xsent_q
	) else $error("no XON below low threshold");

endmodule // pfc_flow_ctrl

// ===== tb/pfc_ctrl_model.sv
// Controller-side partner: sends pause commands, acknowledges PAUSE requests
`timescale 1ns/1ps
module pfc_ctrl_model (
	// Clock and reset
	input  wire logic                    clk_in,
	input  wire logic                    srst_in,
	// Bench control
	input  wire logic                    go_in,
	input  wire logic                    xon_in,
	input  wire logic                    transmit_flow_ctrl_enable_in,
	input  wire logic [2:0]              ack_dly_in,
	input  wire logic                    rx_valid_in,
	// Device side
	output logic                         cmd_valid_out,
	output logic                         cmd_xon_out,
	input  wire logic                    req_valid_in,
	input  wire pfc_pkg::pfc_pause_req_t req_in,
	output logic                         ack_out,
	output pfc_pkg::pfc_pause_req_t      last_out,
	output int                           n_req_out
);
	import pfc_pkg::*;
	logic [2:0] wait_q;

	// Slow acknowledge keeps a request standing over many cycles
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cmd_valid_out <= 1'b0;
			cmd_xon_out   <= 1'b0;
			ack_out       <= 1'b0;
			wait_q        <= 3'h0;
			last_out      <= '0;
			n_req_out     <= 0;
		end else begin
			// Commands only with flow control on and rx_valid_in low in the cycle before
			cmd_valid_out <= go_in & transmit_flow_ctrl_enable_in & ~rx_valid_in;
			// Idle line toggles so a stale level never looks like a command
			cmd_xon_out   <= go_in ? xon_in : ~cmd_xon_out;
			ack_out       <= 1'b0;
			if (ack_out && req_valid_in) begin
				last_out  <= req_in;
				n_req_out <= n_req_out + 1;
			end
			if (req_valid_in && !ack_out) begin
				if (wait_q >= ack_dly_in) begin
					ack_out <= 1'b1;
					wait_q  <= 3'h0;
				end else begin
					wait_q <= wait_q + 3'h1;
				end
			end
		end
	end
endmodule // pfc_ctrl_model

// ===== tb/pfc_flow_ctrl_tb.sv
// Self-checking bench of the pause flow-control engine
`timescale 1ns/1ps
module pfc_flow_ctrl_tb;
	import pfc_pkg::*;
	localparam logic [47:0] MC = PFC_MC_ADDR;
	localparam logic [15:0] TY = PFC_CTRL_TYPE;
	localparam logic [15:0] OP = PFC_PAUSE_OPCODE;
	logic                   clk = 1'b0;
	logic                   srst = 1'b1;
	logic [7:0]             addr = 8'h00;
	logic [31:0]            wdata = 32'h0;
	logic                   wr = 1'b0;
	logic                   rd = 1'b0;
	logic                   rx_v = 1'b0;
	pfc_beat_t              beat = '0;
	logic                   tick = 1'b0;
	logic                   tick_en = 1'b0;
	logic                   en = 1'b1;
	logic                   busy = 1'b0;
	logic                   go = 1'b0;
	logic                   xon = 1'b0;
	logic                   transmit_flow_ctrl_enable = 1'b0;
	logic [2:0]             dly = 3'h0;
	logic [15:0]            rx_fill = 16'h0;
	logic [15:0]            tx_fill = 16'h0;
	logic [31:0]            seed = 32'h4AE2F1DD;
	logic [47:0]            sta = 48'h112233445566;
	logic                   last_x = 1'b0;
	logic [31:0]            rdata;
	logic [31:0]            d;
	logic                   fwd_p, halt, ib_v, ib_x, st_v, st_x, rq_v, ack;
	logic                   fwd_v;
	logic                   rx_v_q = 1'b0;
	pfc_beat_t              fwd_b;
	pfc_beat_t              beat_q = '0;
	pfc_pause_req_t         rq, last_rq;
	int                     n_rq;
	int                     n_fwd = 0;
	int                     n_st = 0;
	int                     n_mismatch = 0;
	int                     checks = 0;
	logic [7:0]             ofs [7] = '{PFC_OFS_CTRL, PFC_OFS_PTIME,
		PFC_OFS_REFRESH, PFC_OFS_THRESH, PFC_OFS_STA_LO, PFC_OFS_STA_HI, 8'h1C};
	logic [31:0]            rst_val [7] = '{{29'h0, PFC_CTRL_RST},
		{16'h0, PFC_PTIME_RST}, {16'h0, PFC_REFRESH_RST},
		{PFC_THR_LO_RST, PFC_THR_HI_RST}, PFC_STA_RST[31:0],
		{16'h0, PFC_STA_RST[47:32]}, 32'h0};

	pfc_flow_ctrl i_dut (
		.clk_sys_in          (clk),
		.srst_in             (srst),
		.clk_en_in           (en),
		.reg_addr_in         (addr),
		.reg_wdata_in        (wdata),
		.reg_wr_in           (wr),
		.reg_rd_in           (rd),
		.reg_rdata_out       (rdata),
		.rx_valid_in         (rx_v),
		.rx_beat_in          (beat),
		.fwd_valid_out       (fwd_v),
		.fwd_beat_out        (fwd_b),
		.fwd_pause_out       (fwd_p),
		.byte_tick_in        (tick),
		.tx_busy_in          (busy),
		.tx_halt_out         (halt),
		.ib_cmd_valid_in     (ib_v),
		.ib_cmd_xon_in       (ib_x),
		.ib_stat_valid_out   (st_v),
		.ib_stat_txoff_out   (st_x),
		.pause_req_valid_out (rq_v),
		.pause_req_out       (rq),
		.pause_req_ack_in    (ack),
		.rx_fill_in          (rx_fill),
		.tx_fill_in          (tx_fill)
	);

	pfc_ctrl_model i_ctrl (
		.clk_in        (clk),
		.srst_in       (srst),
		.go_in         (go),
		.xon_in        (xon),
		.transmit_flow_ctrl_enable_in       (transmit_flow_ctrl_enable),
		.ack_dly_in    (dly),
		.rx_valid_in   (rx_v),
		.cmd_valid_out (ib_v),
		.cmd_xon_out   (ib_x),
		.req_valid_in  (rq_v),
		.req_in        (rq),
		.ack_out       (ack),
		.last_out      (last_rq),
		.n_req_out     (n_rq)
	);

	initial begin
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic roll;
		seed = xs(seed);
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// A used-up wait is a failure and ends the run
	task automatic bound(input logic hit);
		if (hit) begin
			cmp(32'h1, 32'h0);
			tally_and_finish();
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Sends one 18-byte control frame, then checks its whole effect
	task automatic frame(input logic [47:0] da, input logic [15:0] ty,
		input logic [15:0] op, input logic [15:0] tm, input logic ok,
		input logic hl);
		int f0;
		int s0;
		logic [143:0] f;
		f0 = n_fwd;
		s0 = n_st;
		f = {da, 48'h02AABBCCDDEE, ty, op, tm};
		for (int i = 0; i < 18; i++) begin
			@(posedge clk);
			rx_v <= 1'b1;
			beat <= {i == 0, i == 17, f[143 - 8 * i -: 8]};
		end
		@(posedge clk);
		rx_v <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		cmp(32'(n_fwd - f0), {31'h0, ok});
		cmp(32'(n_st - s0), {31'h0, ok});
		cmp({31'h0, halt}, {31'h0, hl});
		if (ok) begin
			cmp({31'h0, last_x}, {31'h0, tm != 16'h0});
			reg_rd(PFC_OFS_STATUS);
			cmp({16'h0, d[15:0]}, {16'h0, tm});
		end
	endtask

	task automatic wait_rq(input int n0, input logic [16:0] e, input int lim);
		int k;
		k = 0;
		while (n_rq == n0 && k < lim) begin
			@(posedge clk);
			#1;
			k++;
		end
		bound(n_rq == n0);
		#1;
		cmp({15'h0, last_rq}, {15'h0, e});
	endtask

	task automatic cmd_chk(input logic x, input logic [16:0] e);
		int n0;
		n0 = n_rq;
		@(posedge clk);
		go <= 1'b1;
		xon <= x;
		dly <= seed[2:0];
		@(posedge clk);
		go <= 1'b0;
		wait_rq(n0, e, 30);
	endtask

	// Status messages may only appear between received packets
	always @(posedge clk) begin
		tick <= tick_en;
		rx_v_q <= rx_v;
		beat_q <= beat;
		if (srst === 1'b0)
			cmp({21'h0, fwd_v, fwd_b}, {21'h0, rx_v_q, beat_q});
		if (fwd_p === 1'b1)
			n_fwd <= n_fwd + 1;
		if (st_v === 1'b1) begin
			n_st <= n_st + 1;
			last_x <= st_x;
			cmp({31'h0, rx_v}, 32'h0);
		end
	end

	initial begin
		logic [15:0] tm;
		logic [15:0] pt;
		int n;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		for (int k = 0; k < 7; k++) begin
			reg_rd(ofs[k]);
			cmp(d, rst_val[k]);
		end
		frame(MC, TY, OP, 16'h0010, 1'b0, 1'b0);
		reg_wr(PFC_OFS_STA_LO, sta[31:0]);
		reg_wr(PFC_OFS_STA_HI, {16'h0, sta[47:32]});
		reg_wr(PFC_OFS_CTRL, 32'h3);
		transmit_flow_ctrl_enable <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			roll();
			tm = (k == 0) ? 16'h0001 : (k == 1) ? 16'hFFFF : seed[15:0] | 16'h1;
			frame(MC, TY, OP, tm, 1'b1, 1'b1);
			frame(MC ^ 48'h1, TY, OP, 16'h0, 1'b0, 1'b1);
			frame(MC, TY ^ 16'h1, OP, 16'h0, 1'b0, 1'b1);
			frame(MC, TY, OP ^ 16'h3, 16'h0, 1'b0, 1'b1);
			frame(sta, TY, OP, 16'h0, 1'b1, 1'b0);
		end
		@(posedge clk);
		busy <= 1'b1;
		frame(MC, TY, OP, 16'h0040, 1'b1, 1'b0);
		@(posedge clk);
		busy <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		cmp({31'h0, halt}, 32'h1);
		frame(MC, TY, OP, 16'h0002, 1'b1, 1'b1);
		// Frozen engine must ignore byte ticks that would expire the timer
		@(posedge clk);
		en <= 1'b0;
		tick_en <= 1'b1;
		repeat (150) @(posedge clk);
		#1;
		cmp({31'h0, halt}, 32'h1);
		@(posedge clk);
		en <= 1'b1;
		n = 0;
		while (halt !== 1'b0 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		bound(halt !== 1'b0);
		cmp({31'h0, n >= 64 && n <= 160}, 32'h1);
		repeat (4) @(posedge clk);
		#1;
		cmp({31'h0, last_x}, 32'h0);
		@(posedge clk);
		tick_en <= 1'b0;
		roll();
		pt = seed[15:0];
		reg_wr(PFC_OFS_PTIME, seed);
		reg_rd(PFC_OFS_PTIME);
		cmp({16'h0, d[15:0]}, {16'h0, pt});
		cmd_chk(1'b0, {1'b0, pt});
		roll();
		cmd_chk(1'b1, 17'h10000);
		// Short refresh keeps the repeat of an XOFF within a few slots
		reg_wr(PFC_OFS_REFRESH, 32'h1);
		reg_wr(PFC_OFS_CTRL, 32'h7);
		@(posedge clk);
		rx_fill <= 16'h0400;
		tx_fill <= 16'h0400;
		n = n_rq;
		repeat (20) @(posedge clk);
		cmp(32'(n_rq - n), 32'h0);
		roll();
		@(posedge clk);
		tx_fill <= 16'h0401 + {6'h0, seed[9:0]};
		wait_rq(n, {1'b0, pt}, 20);
		roll();
		@(posedge clk);
		tx_fill <= {6'h0, seed[9:0]} | 16'h1;
		tick_en <= 1'b1;
		wait_rq(n_rq, {1'b0, pt}, 300);
		@(posedge clk);
		tick_en <= 1'b0;
		rx_fill <= {7'h0, seed[8:0]};
		tx_fill <= 16'h0;
		wait_rq(n_rq, 17'h10000, 20);
		tally_and_finish();
	end
endmodule // pfc_flow_ctrl_tb
